// File: bsd_cmd_if.sv
// Carrier between the register front end and the instruction decoder
`timescale 1ns/10ps
interface bsd_cmd_if;
  import bsd_pkg::*;
  logic go;
  logic [23:0] word;
  logic hit;
  bsd_func_e func;
  logic [7:0] ctl;
  modport src (output go, output word, input hit, input func, input ctl);
  modport dec (input go, input word, output hit, output func, output ctl);
endinterface : bsd_cmd_if

// File: bsd_decode.sv
// Combinational decode of a start-I/O instruction word
`timescale 1ns/10ps
`include "bsd_defs.svh"
module bsd_decode (
  // Command carrier
  bsd_cmd_if.dec cmd
);
  import bsd_pkg::*;

  always_comb begin
    cmd.hit = cmd.go
      && (cmd.word[`BSD_OP_HI:`BSD_OP_LO] == `BSD_OP_SIO)
      && (cmd.word[`BSD_DEV_HI:`BSD_DEV_LO] == `BSD_DEV_ADDR)
      && !cmd.word[`BSD_MOD_BIT];
    cmd.ctl = cmd.word[`BSD_CTL_HI:`BSD_CTL_LO];
    unique case (cmd.word[`BSD_FN_HI:`BSD_FN_LO])
      `BSD_FN_CTL: cmd.func = BSD_CTL;
      `BSD_FN_RX: cmd.func = BSD_RX;
      `BSD_FN_TXRX: cmd.func = BSD_TXRX;
      `BSD_FN_IRX: cmd.func = BSD_IRX;
      `BSD_FN_MCTL: cmd.func = BSD_MCTL;
      `BSD_FN_DUMP: cmd.func = BSD_DUMP;
      default: cmd.func = BSD_NONE; // see (RULE20)
    endcase
  end

endmodule : bsd_decode

// File: bsd_defs.svh
// Constants for the start-I/O decoder of the bisync communications controller
`ifndef BSD_DEFS_SVH
`define BSD_DEFS_SVH

// ------------------------------------------------------------------
// Instruction word layout (word bit 23 is instruction bit 0)
// ------------------------------------------------------------------
`define BSD_OP_HI 23
`define BSD_OP_LO 16
`define BSD_DEV_HI 15
`define BSD_DEV_LO 12
`define BSD_MOD_BIT 11
`define BSD_FN_HI 10
`define BSD_FN_LO 8
`define BSD_CTL_HI 7
`define BSD_CTL_LO 0
`define BSD_OP_SIO 8'hF3
`define BSD_DEV_ADDR 4'h2

// ------------------------------------------------------------------
// Function field codes
// ------------------------------------------------------------------
`define BSD_FN_CTL 3'h0
`define BSD_FN_RX 3'h1
`define BSD_FN_TXRX 3'h2
`define BSD_FN_IRX 3'h3
`define BSD_FN_MCTL 3'h5
`define BSD_FN_DUMP 3'h6

// ------------------------------------------------------------------
// Control set bytes
// ------------------------------------------------------------------
`define BSD_C_INT_EN 8'h01
`define BSD_C_LOAD_BUF 8'h02
`define BSD_C_INIT_LOAD 8'h08
`define BSD_C_SC_EN 8'h10
`define BSD_C_MRST_SET 8'h20
`define BSD_C_ATT_EN 8'h40
`define BSD_C_INT_DIS 8'h81
`define BSD_C_INT_CLR 8'h82
`define BSD_C_START_CLK 8'h88
`define BSD_C_SC_DIS 8'h90
`define BSD_C_MRST_CLR 8'hA0
`define BSD_C_ATT_DIS 8'hC0

// ------------------------------------------------------------------
// Microcontroller set bytes
// ------------------------------------------------------------------
`define BSD_M_TMR_START 8'h01
`define BSD_M_TRC_START 8'h08
`define BSD_M_TEST_ON 8'h40
`define BSD_M_TMR_CANCEL 8'h81
`define BSD_M_LINE_DIS 8'h82
`define BSD_M_TRC_STOP 8'h84
`define BSD_M_POLL_STOP 8'hA0
`define BSD_M_TEST_OFF 8'hC0

// ------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ------------------------------------------------------------------
`define BSD_REG_CMD 3'h0
`define BSD_REG_STATUS 3'h1
`define BSD_REG_UPBUF 3'h2
`define BSD_REG_TRACE 3'h3

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define BSD_CLK_HZ 25000000
`define BSD_TIMER_SEC 2
`define BSD_TRACE_DEPTH 16

`endif

// File: bsd_micro_model.sv
// Microcontroller-side model feeding the decoder
`timescale 1ns/10ps
module bsd_micro_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic int_req_i,
  input wire logic done_req_i,
  // Toward the decoder
  output logic int_event_o,
  output logic init_load_done_o,
  output logic [7:0] micro_data_o
);
  // Requests leave as registered events launched after an edge, lasting as long as the request is held
  always_ff @(posedge clk_i) begin
    int_event_o <= !rst_i && int_req_i;
    init_load_done_o <= !rst_i && done_req_i;
  end
  assign micro_data_o = 8'h5A;
endmodule : bsd_micro_model

// File: bsd_pkg.sv
// Types shared by the start-I/O decoder modules
package bsd_pkg;

  typedef enum logic [2:0] {
    BSD_NONE,
    BSD_CTL,
    BSD_RX,
    BSD_TXRX,
    BSD_IRX,
    BSD_MCTL,
    BSD_DUMP
  } bsd_func_e;

  typedef enum logic {
    BSD_DS_IDLE,
    BSD_DS_DUMP
  } bsd_dump_e;

endpackage : bsd_pkg

// File: bsd_sio_decoder.sv
// Start-I/O decoder of the bisync communications controller, Wishbone front end
// Contract
// (RULE1) Only operation code F3 is decoded as a start-I/O command.
// (RULE2) Fields: device address, modifier at bit 12, function, control byte from 16.
// (RULE3) Respond only to device address 0010 with modifier bit zero.
// (RULE4) Function 000 selects attachment control actions by control byte.
// (RULE5) Function 001 receive only, 010 transmit and receive, 011 initial receive.
// (RULE6) Function 101 selects microcontroller actions by control byte.
// (RULE7) Function 110 dumps the service trace to the processor.
// (RULE8) Control 01 enables, 81 disables interrupts, 82 clears pending interrupt.
// (RULE9) Control 02 loads the microcontroller-to-processor buffer.
// (RULE10) Control 08 sets the initial microprogram load condition.
// (RULE11) Control 10 enables, 90 disables single-cycle mode.
// (RULE12) Control 20 asserts, A0 removes microcontroller reset.
// (RULE13) Control 40 enables, C0 disables the attachment.
// (RULE14) Control 88 issues one microcontroller start clock pulse.
// (RULE15) Micro set 01 starts the two-second timer, 81 cancels it.
// (RULE16) Micro set 08 starts the service trace, 84 stops it.
// (RULE17) Micro set 40 turns test mode on, C0 turns it off.
// (RULE18) Micro set 82 disables the selected communication line.
// (RULE19) Micro set A0 stops polling.
// (RULE20) Unused or unlisted codes change no state. The code records them in the service trace while tracing.
// (RULE21) In single-cycle mode the microcontroller steps once per start pulse.
// (RULE22) Interrupt request shows only while enabled and pending.
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "bsd_defs.svh"
module bsd_sio_decoder #(
  parameter int unsigned TIMER_CYCLES = `BSD_TIMER_SEC * `BSD_CLK_HZ,
  parameter int TRACE_DEPTH = `BSD_TRACE_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Microcontroller side
  input wire logic int_event_i,
  input wire logic init_load_done_i,
  input wire logic [7:0] micro_data_i,
  output logic micro_reset_o,
  output logic initial_microprogram_load_o,
  output logic single_cycle_o,
  output logic micro_step_o,
  output logic attach_en_o,
  output logic load_buf_o,
  output logic test_mode_o,
  output logic trace_on_o,
  output logic timer_expired_o,
  // Line operations
  output logic line_rx_o,
  output logic line_txrx_o,
  output logic line_irx_o,
  output logic [7:0] line_ctl_o,
  output logic line_disable_o,
  output logic poll_stop_o,
  // Processor interrupt
  output logic irq_o
);
  import bsd_pkg::*;

  localparam int TW = $clog2(TIMER_CYCLES + 1);
  localparam int PW = $clog2(TRACE_DEPTH + 1);

  // ------------------------------------------------------------------
  // Wishbone access strobes
  // ------------------------------------------------------------------
  logic req;
  logic wr_fire;
  logic rd_take;
  logic [2:0] reg_idx;
  logic adr_hi_zero;

  assign req = wb_cyc_i && wb_stb_i;
  assign reg_idx = wb_adr_i[4:2];
  assign adr_hi_zero = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0);
  // Writes act at the edge where the master sees ack
  assign wr_fire = req && wb_we_i && wb_ack_o;
  // Read data is captured as ack is raised
  assign rd_take = req && !wb_we_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  // ------------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------------
  bsd_cmd_if cmd ();

  // The whole 24-bit word must be written at once to issue a command
  assign cmd.go = wr_fire && adr_hi_zero && (reg_idx == `BSD_REG_CMD)
    && (wb_sel_i[2:0] == 3'h7);
  assign cmd.word = wb_dat_i[23:0];

  bsd_decode u_decode (
    .cmd(cmd)
  ); // see (RULE1) see (RULE2) see (RULE3)

  logic ctl_hit;
  logic mctl_hit;
  assign ctl_hit = cmd.hit && (cmd.func == BSD_CTL); // see (RULE4)
  assign mctl_hit = cmd.hit && (cmd.func == BSD_MCTL); // see (RULE6)

  // Control set action strobes; unlisted bytes match nothing
  logic c_int_en, c_int_dis, c_int_clr, c_load, c_init_load, c_sc_en, c_sc_dis;
  logic c_mrst_set, c_mrst_clr, c_att_en, c_att_dis, c_start_clk;
  assign c_int_en = ctl_hit && (cmd.ctl == `BSD_C_INT_EN); // see (RULE8)
  assign c_int_dis = ctl_hit && (cmd.ctl == `BSD_C_INT_DIS); // see (RULE8)
  assign c_int_clr = ctl_hit && (cmd.ctl == `BSD_C_INT_CLR); // see (RULE8)
  assign c_load = ctl_hit && (cmd.ctl == `BSD_C_LOAD_BUF); // see (RULE9)
  assign c_init_load = ctl_hit && (cmd.ctl == `BSD_C_INIT_LOAD); // see (RULE10)
  assign c_sc_en = ctl_hit && (cmd.ctl == `BSD_C_SC_EN); // see (RULE11)
  assign c_sc_dis = ctl_hit && (cmd.ctl == `BSD_C_SC_DIS); // see (RULE11)
  assign c_mrst_set = ctl_hit && (cmd.ctl == `BSD_C_MRST_SET); // see (RULE12)
  assign c_mrst_clr = ctl_hit && (cmd.ctl == `BSD_C_MRST_CLR); // see (RULE12)
  assign c_att_en = ctl_hit && (cmd.ctl == `BSD_C_ATT_EN); // see (RULE13)
  assign c_att_dis = ctl_hit && (cmd.ctl == `BSD_C_ATT_DIS); // see (RULE13)
  assign c_start_clk = ctl_hit && (cmd.ctl == `BSD_C_START_CLK); // see (RULE14)

  // Microcontroller set action strobes
  logic m_tmr_start, m_tmr_cancel, m_trc_start, m_trc_stop;
  logic m_test_on, m_test_off, m_line_dis, m_poll_stop;
  assign m_tmr_start = mctl_hit && (cmd.ctl == `BSD_M_TMR_START); // see (RULE15)
  assign m_tmr_cancel = mctl_hit && (cmd.ctl == `BSD_M_TMR_CANCEL); // see (RULE15)
  assign m_trc_start = mctl_hit && (cmd.ctl == `BSD_M_TRC_START); // see (RULE16)
  assign m_trc_stop = mctl_hit && (cmd.ctl == `BSD_M_TRC_STOP); // see (RULE16)
  assign m_test_on = mctl_hit && (cmd.ctl == `BSD_M_TEST_ON); // see (RULE17)
  assign m_test_off = mctl_hit && (cmd.ctl == `BSD_M_TEST_OFF); // see (RULE17)
  assign m_line_dis = mctl_hit && (cmd.ctl == `BSD_M_LINE_DIS); // see (RULE18)
  assign m_poll_stop = mctl_hit && (cmd.ctl == `BSD_M_POLL_STOP); // see (RULE19)

  // ------------------------------------------------------------------
  // Interrupt enable and pending
  // ------------------------------------------------------------------
  logic int_en;
  logic int_pend;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en <= 1'b0;
    end else if (c_int_en) begin
      int_en <= 1'b1;
    end else if (c_int_dis) begin
      int_en <= 1'b0;
    end
  end

  // A new event in the clearing cycle keeps the interrupt pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_pend <= 1'b0;
    end else if (int_event_i) begin
      int_pend <= 1'b1;
    end else if (c_int_clr) begin
      int_pend <= 1'b0; // see (RULE8)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= int_en && int_pend; // see (RULE22)
    end
  end

  // ------------------------------------------------------------------
  // Attachment and microcontroller control levels
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attach_en_o <= 1'b0;
    end else if (c_att_en) begin
      attach_en_o <= 1'b1;
    end else if (c_att_dis) begin
      attach_en_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      micro_reset_o <= 1'b0;
    end else if (c_mrst_set) begin
      micro_reset_o <= 1'b1;
    end else if (c_mrst_clr) begin
      micro_reset_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      single_cycle_o <= 1'b0;
    end else if (c_sc_en) begin
      single_cycle_o <= 1'b1;
    end else if (c_sc_dis) begin
      single_cycle_o <= 1'b0;
    end
  end

  // Load condition holds until the microcontroller reports it done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      initial_microprogram_load_o <= 1'b0;
    end else if (c_init_load) begin
      initial_microprogram_load_o <= 1'b1;
    end else if (init_load_done_i) begin
      initial_microprogram_load_o <= 1'b0;
    end
  end

  // Free running unless held in reset or stepped one cycle at a time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      micro_step_o <= 1'b0;
    end else if (micro_reset_o) begin
      micro_step_o <= 1'b0;
    end else if (single_cycle_o) begin
      micro_step_o <= c_start_clk; // see (RULE21)
    end else begin
      micro_step_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_mode_o <= 1'b0;
    end else if (m_test_on) begin
      test_mode_o <= 1'b1;
    end else if (m_test_off) begin
      test_mode_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // One-cycle command pulses to line and microcontroller logic
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_rx_o <= 1'b0;
      line_txrx_o <= 1'b0;
      line_irx_o <= 1'b0;
      line_disable_o <= 1'b0;
      poll_stop_o <= 1'b0;
      load_buf_o <= 1'b0;
    end else begin
      line_rx_o <= cmd.hit && (cmd.func == BSD_RX); // see (RULE5)
      line_txrx_o <= cmd.hit && (cmd.func == BSD_TXRX); // see (RULE5)
      line_irx_o <= cmd.hit && (cmd.func == BSD_IRX); // see (RULE5)
      line_disable_o <= m_line_dis;
      poll_stop_o <= m_poll_stop;
      load_buf_o <= c_load;
    end
  end

  // Control byte that travels with a line operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_ctl_o <= 8'h00;
    end else if (cmd.hit && ((cmd.func == BSD_RX) || (cmd.func == BSD_TXRX)
        || (cmd.func == BSD_IRX))) begin
      line_ctl_o <= cmd.ctl;
    end
  end

  // Buffer that carries a byte from the microcontroller to the processor
  logic [7:0] up_buf;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_buf <= 8'h00;
    end else if (c_load) begin
      up_buf <= micro_data_i; // see (RULE9)
    end
  end

  // ------------------------------------------------------------------
  // Two-second timer
  // ------------------------------------------------------------------
  logic tmr_run;
  logic tmr_exp;
  logic tmr_done;

  bsd_timer #(
    .CYCLES(TIMER_CYCLES),
    .W(TW)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(m_tmr_start),
    .cancel_i(m_tmr_cancel),
    .running_o(tmr_run),
    .expired_o(tmr_exp)
  ); // see (RULE15)

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_expired_o <= 1'b0;
    end else begin
      timer_expired_o <= tmr_exp;
    end
  end

  // Sticky expiry flag; expiry wins over a clearing command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_done <= 1'b0;
    end else if (tmr_exp) begin
      tmr_done <= 1'b1;
    end else if (m_tmr_start || m_tmr_cancel) begin
      tmr_done <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Service trace capture and dump
  // ------------------------------------------------------------------
  logic [23:0] trace_mem [TRACE_DEPTH];
  logic [PW-1:0] trace_cnt;
  logic [PW-1:0] rd_ptr;
  bsd_dump_e dump_state;
  logic trace_rd;

  assign trace_rd = rd_take && adr_hi_zero && (reg_idx == `BSD_REG_TRACE)
    && (dump_state == BSD_DS_DUMP);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_on_o <= 1'b0;
    end else if (m_trc_start) begin
      trace_on_o <= 1'b1; // see (RULE16)
    end else if (m_trc_stop) begin
      trace_on_o <= 1'b0;
    end
  end

  // Each decoded instruction other than a trace start is recorded while tracing, until full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_cnt <= '0;
    end else if (m_trc_start) begin
      trace_cnt <= '0;
    end else if (trace_on_o && cmd.hit && (trace_cnt < PW'(TRACE_DEPTH))) begin
      trace_mem[trace_cnt[PW-2:0]] <= cmd.word;
      trace_cnt <= trace_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dump_state <= BSD_DS_IDLE;
      rd_ptr <= '0;
    end else begin
      unique case (dump_state)
        BSD_DS_IDLE: begin
          if (cmd.hit && (cmd.func == BSD_DUMP) && (trace_cnt != '0)) begin
            dump_state <= BSD_DS_DUMP; // see (RULE7)
            rd_ptr <= '0;
          end
        end
        BSD_DS_DUMP: begin
          if (trace_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
            if (rd_ptr + 1'b1 >= trace_cnt) begin
              dump_state <= BSD_DS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------------
  logic [31:0] status_word;
  assign status_word = {11'h000, trace_cnt[4:0] & 5'h1F, 5'h00,
    (dump_state == BSD_DS_DUMP), test_mode_o, trace_on_o, tmr_done, tmr_run,
    initial_microprogram_load_o, micro_reset_o, single_cycle_o, attach_en_o,
    int_pend, int_en};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_take) begin
      wb_dat_o <= 32'h00000000;
      if (adr_hi_zero) begin
        unique case (reg_idx)
          `BSD_REG_STATUS: wb_dat_o <= status_word;
          `BSD_REG_UPBUF: wb_dat_o <= {24'h000000, up_buf};
          `BSD_REG_TRACE: begin
            if (dump_state == BSD_DS_DUMP) begin
              wb_dat_o <= {8'h00, trace_mem[rd_ptr[PW-2:0]]};
            end
          end
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : bsd_sio_decoder

// File: bsd_sio_monitor.sv
// Port checker for the start-I/O decoder
`timescale 1ns/10ps
module bsd_sio_monitor (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Decoded outputs
  input wire logic single_cycle_o,
  input wire logic micro_reset_o,
  input wire logic micro_step_o,
  input wire logic attach_en_o,
  input wire logic load_buf_o,
  input wire logic line_rx_o,
  input wire logic line_txrx_o,
  input wire logic line_irx_o,
  input wire logic line_disable_o,
  input wire logic poll_stop_o
);
  logic ok;
  logic [2:0] fn;
  logic [7:0] cb;
  // Accepted command write at the acknowledging edge
  assign ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00
    && wb_sel_i[2:0] == 3'h7 && wb_dat_i[23:16] == 8'hF3 && wb_dat_i[15:11] == 5'h04;
  assign fn = wb_dat_i[10:8];
  assign cb = wb_dat_i[7:0];
  default clocking mon_clk @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_LINE_OPS: assert property ({line_rx_o, line_txrx_o, line_irx_o} ==
    $past({ok && fn == 3'h1, ok && fn == 3'h2, ok && fn == 3'h3}))
    else $error("line operation pulse wrong");
  AST_LOAD_BUF: assert property (load_buf_o == $past(ok && fn == 3'h0 && cb == 8'h02))
    else $error("load buffer pulse wrong");
  AST_MICRO_PULSE: assert property ({line_disable_o, poll_stop_o} ==
    $past({ok && fn == 3'h5 && cb == 8'h82, ok && fn == 3'h5 && cb == 8'hA0}))
    else $error("line disable or poll stop pulse wrong");
  AST_ATTACH: assert property (ok && fn == 3'h0 && (cb == 8'h40 || cb == 8'hC0)
    |=> attach_en_o == $past(cb == 8'h40)) else $error("attach enable wrong");
  AST_HOLD: assert property (!$past(ok) |-> $stable(attach_en_o))
    else $error("attach enable changed without command");
  AST_SINGLE: assert property (ok && fn == 3'h0 && (cb == 8'h10 || cb == 8'h90)
    |=> single_cycle_o == $past(cb == 8'h10)) else $error("single cycle wrong");
  AST_MRESET: assert property (ok && fn == 3'h0 && (cb == 8'h20 || cb == 8'hA0)
    |=> micro_reset_o == $past(cb == 8'h20)) else $error("micro reset wrong");
  AST_STEP: assert property (single_cycle_o && $past(single_cycle_o) && !micro_reset_o
    && !$past(micro_reset_o) |-> micro_step_o == $past(ok && fn == 3'h0 && cb == 8'h88))
    else $error("single step pulse wrong");
endmodule : bsd_sio_monitor

bind bsd_sio_decoder bsd_sio_monitor bsd_sio_monitor_inst (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .single_cycle_o,
  .micro_reset_o, .micro_step_o, .attach_en_o, .load_buf_o, .line_rx_o, .line_txrx_o,
  .line_irx_o, .line_disable_o, .poll_stop_o);

// File: bsd_timer.sv
// One-shot interval timer with start and cancel
`timescale 1ns/10ps
module bsd_timer #(
  parameter int unsigned CYCLES = 50000000,
  parameter int W = 26
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic cancel_i,
  // Status
  output logic running_o,
  output logic expired_o
);

  logic [W-1:0] count;

  always_ff @(posedge clk_i) begin
    expired_o <= 1'b0;
    if (rst_i || cancel_i) begin
      running_o <= 1'b0;
      count <= '0;
    end else if (start_i) begin
      running_o <= 1'b1;
      count <= W'(CYCLES - 1);
    end else if (running_o) begin
      if (count == '0) begin
        running_o <= 1'b0;
        expired_o <= 1'b1;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : bsd_timer

// File: testbench.sv
// Self-checking bench for the start-I/O decoder
`timescale 1ns/10ps
`include "bsd_defs.svh"
module testbench;
  import bsd_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, int_req, done_req, count_on;
  logic int_event_i, init_load_done_i, micro_reset_o, initial_microprogram_load_o;
  logic single_cycle_o, micro_step_o, attach_en_o, load_buf_o, test_mode_o, trace_on_o;
  logic timer_expired_o, line_rx_o, line_txrx_o, line_irx_o, line_disable_o, poll_stop_o;
  logic irq_o, found, tmr_seen;
  logic [7:0] wb_adr_i, micro_data_i, line_ctl_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int checks, mismatches, steps;
  logic [7:0] cs [10] = '{8'h01, 8'h40, 8'h10, 8'h20, 8'h08, 8'h04, 8'h90, 8'hA0, 8'hC0, 8'h81};
  logic [31:0] ce [10] = '{32'h01, 32'h05, 32'h0D, 32'h1D, 32'h3D, 32'h3D, 32'h35, 32'h25,
    32'h21, 32'h20};
  logic [31:0] bad [5] = '{32'h00F20040, 32'h00F33040, 32'h00F32840, 32'h00F32740, 32'h00F32440};
  bsd_sio_decoder #(.TIMER_CYCLES(20)) bsd_sio_decoder_inst (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_event_i,
    .init_load_done_i, .micro_data_i, .micro_reset_o, .initial_microprogram_load_o,
    .single_cycle_o, .micro_step_o, .attach_en_o, .load_buf_o, .test_mode_o, .trace_on_o,
    .timer_expired_o, .line_rx_o, .line_txrx_o, .line_irx_o, .line_ctl_o, .line_disable_o,
    .poll_stop_o, .irq_o);
  bsd_micro_model bsd_micro_model_inst (.clk_i, .rst_i, .int_req_i(int_req),
    .done_req_i(done_req), .int_event_o(int_event_i), .init_load_done_o(init_load_done_i),
    .micro_data_o(micro_data_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (count_on && micro_step_o === 1'b1) steps++;
  always @(posedge clk_i) tmr_seen <= !rst_i && (tmr_seen || timer_expired_o === 1'b1);
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One classic cycle: hold until ack is sampled, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      conclude();
    end
  endtask : xfer
  task automatic sio(input logic [2:0] f, input logic [7:0] c);
    xfer(1'b1, 8'h00, {8'h00, `BSD_OP_SIO, `BSD_DEV_ADDR, 1'b0, f, c});
  endtask : sio
  task automatic st(input logic [31:0] exp);
    xfer(1'b0, 8'h04, 32'h0);
    check("status", q & 32'hFFFF, exp);
  endtask : st
  task automatic pulse(input logic which);
    @(posedge clk_i);
    if (which) int_req <= 1'b1;
    else done_req <= 1'b1;
    @(posedge clk_i);
    int_req <= 1'b0;
    done_req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, int_req, done_req, count_on, found} = 7'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    steps = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    st(32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 10; i++) begin
      sio(3'h0, cs[i]);
      st(ce[i]);
    end
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 8'h00, bad[i]);
      st(32'h20);
    end
    wb_sel_i <= 4'h3;
    sio(3'h0, 8'h40);
    wb_sel_i <= 4'hF;
    st(32'h20);
    pulse(1'b0);
    st(32'h0);
    $display("test control set done");
    sio(3'h0, 8'h01);
    pulse(1'b1);
    check("irq", irq_o, 1'b1);
    sio(3'h0, 8'h81);
    repeat (3) @(posedge clk_i);
    check("irq", irq_o, 1'b0);
    st(32'h2);
    sio(3'h0, 8'h01);
    sio(3'h0, 8'h82);
    repeat (3) @(posedge clk_i);
    check("irq", irq_o, 1'b0);
    sio(3'h0, 8'h81);
    st(32'h0);
    sio(3'h0, 8'h02);
    xfer(1'b0, 8'h08, 32'h0);
    check("upbuf", q, 32'h5A);
    $display("test interrupt and buffer done");
    sio(3'h0, 8'h10);
    repeat (3) @(posedge clk_i);
    count_on <= 1'b1;
    sio(3'h0, 8'h88);
    sio(3'h0, 8'h88);
    repeat (3) @(posedge clk_i);
    count_on <= 1'b0;
    check("steps", steps, 32'h2);
    sio(3'h0, 8'h90);
    for (int f = 1; f < 4; f++) begin
      sio(f[2:0], 8'h10 + f[7:0]);
      @(posedge clk_i);
      check("line_ctl", line_ctl_o, 8'h10 + f[7:0]);
    end
    st(32'h0);
    $display("test single cycle and line done");
    sio(3'h5, 8'h01);
    st(32'h40);
    check("early_expiry", tmr_seen, 1'b0);
    repeat (30) @(posedge clk_i);
    st(32'h80);
    check("timer_expired", tmr_seen, 1'b1);
    sio(3'h5, 8'h01);
    sio(3'h5, 8'h81);
    st(32'h0);
    sio(3'h5, 8'h08);
    sio(3'h5, 8'h40);
    st(32'h300);
    sio(3'h5, 8'h82);
    sio(3'h5, 8'hA0);
    sio(3'h5, 8'h84);
    sio(3'h5, 8'hC0);
    st(32'h0);
    sio(3'h6, 8'h00);
    st(32'h400);
    for (int i = 0; i < 17; i++) begin
      xfer(1'b0, 8'h0C, 32'h0);
      if (q === 32'h00F32540) found = 1'b1;
    end
    check("trace", found, 1'b1);
    st(32'h0);
    $display("test micro set done");
    conclude();
  end
endmodule : testbench
